// ==== can_err_pkg.sv ====
`default_nettype none
package can_err_pkg;

	// ------------------------------------------------------------
	// bus levels and frame fields
	// ------------------------------------------------------------
	localparam logic DOMINANT  = 1'h0;
	localparam logic RECESSIVE = 1'h1;

	// field codes given by the frame sequencer
	typedef enum logic [3:0] {
		FLD_IDLE    = 4'h0,
		FLD_SOF     = 4'h1,
		FLD_ARB     = 4'h2,
		FLD_CTRL    = 4'h3,
		FLD_DATA    = 4'h4,
		FLD_CRC     = 4'h5,
		FLD_CRC_DEL = 4'h6,
		FLD_ACK     = 4'h7,
		FLD_ACK_DEL = 4'h8,
		FLD_EOF     = 4'h9,
		FLD_INTER   = 4'hA
	} field_t;

	// signalling state machine
	typedef enum logic [2:0] {
		SIG_IDLE   = 3'h0,
		SIG_FLAG   = 3'h1,
		SIG_PFLAG  = 3'h2,
		SIG_WAITR  = 3'h3,
		SIG_DELIM  = 3'h4,
		SIG_BUSOFF = 3'h5
	} sig_state_t;

	// ------------------------------------------------------------
	// counts and limits
	// ------------------------------------------------------------
	localparam int unsigned CRC_W      = 15;
	localparam logic [14:0] CRC_POLY   = 15'h4599;
	localparam logic [14:0] CRC_INIT   = 15'h0000;
	localparam logic [2:0]  FLAG_BITS  = 3'h6;
	localparam logic [2:0]  STUFF_RUN  = 3'h5;
	localparam logic [2:0]  DELIM_REST = 3'h7;
	localparam logic [8:0]  WARN_LIM   = 9'h060;
	localparam logic [8:0]  PASS_LIM   = 9'h07F;
	localparam logic [8:0]  BOFF_LIM   = 9'h0FF;

endpackage
`default_nettype wire

// ==== can_crc15.sv ====
`timescale 1ns/1ps
`default_nettype none
module can_crc15 #(
	parameter int unsigned  W    = 15,
	parameter logic [14:0]  POLY = 15'h4599
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// control
	input  wire logic          clr,
	input  wire logic          en,
	input  wire logic          din,
	// remainder
	output logic [W-1:0]       crc
);
	// ------------------------------------------------------------
	// serial modulo-2 divider
	// ------------------------------------------------------------
	logic          fb;
	logic [W-1:0]  nxt;

	assign fb  = din ^ crc[W-1];
	assign nxt = {crc[W-2:0], 1'b0} ^ (fb ? POLY[W-1:0] : '0);

	// remainder register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			crc <= '0;
		else if (clr)
			crc <= '0;
		else if (en)
			crc <= nxt;
	end
endmodule
`default_nettype wire

// ==== can_error_detect_signal.sv ====
//
// Behaviour
// - bit/stuff/form/ack error: flag next bit
// - crc error: flag after ack delimiter
// - passive flag ends on six equal bits
// - await recessive edge, then seven recessive bits
// - deviation in error frame restarts it
// - never start receiver-not-ready overload frame
// - overload one bit after intermission dominant
// - overload causes no retransmission
// - deviation in overload frame sends error frame
// - transmitter compares driven and sampled bit
// - recessive overwritten in arbitration: lost
// - no transmitter bit error in ack slot
// - more than five equal bits: stuff error
// - crc over destuffed sof to data
// - generator 1100010110011001 remainder
// - dominant in fixed recessive fields: form error
// - transmitter without dominant ack: ack error
// - bus-off until reset request cleared, counters zero
// - drive dominant ack after valid reception
// - error-active sends dominant active flag
// - insert stuff bit after five equal bits
// - error-passive above 127
// - bus-off when transmit counter above 255
// - warning when counter above 96
`timescale 1ns/1ps
`default_nettype none
module can_error_detect_signal (
	// clock and reset
	input  wire logic                    CLK,
	input  wire logic                    SYS_RST,
	// bit timing strobes
	input  wire logic                    BIT_TICK,
	input  wire logic                    RX_BIT,
	// frame sequencer
	input  wire can_err_pkg::field_t     FIELD,
	input  wire logic                    TX_ACTIVE,
	input  wire logic                    TX_BIT,
	input  wire logic                    STUFF_FIELD,
	input  wire logic                    FRAME_START,
	input  wire logic                    MSG_VALID,
	// error counters and software control
	input  wire logic [8:0]              TX_ERR_CNT,
	input  wire logic [7:0]              RX_ERR_CNT,
	input  wire logic                    RESET_REQ,
	// bus drive
	output logic                         TX_PIN,
	output logic                         STUFF_INSERT,
	// status
	output logic                         BIT_ERR,
	output logic                         STUFF_ERR,
	output logic                         CRC_ERR,
	output logic                         FORM_ERR,
	output logic                         ACK_ERR,
	output logic                         ARB_LOST,
	output logic                         OVERLOAD,
	output logic                         RETX_REQ,
	output logic                         ERR_PASSIVE,
	output logic                         BUS_OFF,
	output logic                         ERR_WARN,
	output logic                         CRC_OUT_BIT
);
	// ------------------------------------------------------------
	// decode of frame position
	// ------------------------------------------------------------
	wire logic in_arb    = (FIELD == can_err_pkg::FLD_ARB);
	wire logic in_ack    = (FIELD == can_err_pkg::FLD_ACK);
	wire logic in_ackdel = (FIELD == can_err_pkg::FLD_ACK_DEL);
	wire logic in_crc    = (FIELD == can_err_pkg::FLD_CRC);
	wire logic crc_cover = (FIELD == can_err_pkg::FLD_SOF)
		|| in_arb || (FIELD == can_err_pkg::FLD_CTRL)
		|| (FIELD == can_err_pkg::FLD_DATA);
	wire logic fixed_rec = (FIELD == can_err_pkg::FLD_CRC_DEL)
		|| in_ackdel || (FIELD == can_err_pkg::FLD_EOF);
	wire logic rx_dom    = (RX_BIT == can_err_pkg::DOMINANT);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	can_err_pkg::sig_state_t state_q, state_d;
	logic [2:0]  run_q, run_d;
	logic        last_q, last_d;
	logic [2:0]  cnt_q, cnt_d;
	logic        ovl_q, ovl_d;
	logic        crc_pend_q, crc_pend_d;
	logic        stuff_next_q, stuff_next_d;
	logic [14:0] crc_val;
	logic [3:0]  crc_idx_q, crc_idx_d;

	// ------------------------------------------------------------
	// crc over destuffed bits
	// ------------------------------------------------------------
	wire logic crc_en = BIT_TICK && crc_cover && !stuff_next_q;
	can_crc15 #(
		.W    (can_err_pkg::CRC_W),
		.POLY (can_err_pkg::CRC_POLY)
	) u_crc (
		.clk (CLK),
		.rst (SYS_RST),
		.clr (FRAME_START),
		.en  (crc_en),
		.din (RX_BIT),
		.crc (crc_val)
	);

	// ------------------------------------------------------------
	// error detection
	// ------------------------------------------------------------
	wire logic busy    = (state_q != can_err_pkg::SIG_IDLE);
	wire logic crc_last = (crc_idx_q == 4'(can_err_pkg::CRC_W - 1));
	wire logic stuff_e = !busy && STUFF_FIELD && stuff_next_q
		&& (RX_BIT == last_q);
	wire logic arb_l   = !busy && TX_ACTIVE && in_arb
		&& TX_BIT && rx_dom;
	wire logic bit_e   = !busy && TX_ACTIVE && !in_ack && !stuff_next_q
		&& (TX_BIT != RX_BIT) && !arb_l;
	wire logic form_e  = !busy && fixed_rec && rx_dom;
	wire logic ack_e   = !busy && TX_ACTIVE && in_ack && !rx_dom;
	wire logic crc_bit = crc_val[4'(can_err_pkg::CRC_W - 1) - crc_idx_q];
	wire logic crc_e   = !busy && !TX_ACTIVE && in_crc && !stuff_next_q
		&& (RX_BIT != crc_bit);
	// deviation of an error or overload frame's fixed form
	wire logic dev_e   = ((state_q == can_err_pkg::SIG_FLAG) && !rx_dom)
		|| ((state_q == can_err_pkg::SIG_DELIM) && rx_dom);
	wire logic now_e   = stuff_e || bit_e || form_e || ack_e;
	wire logic late_e  = (crc_pend_q || crc_e) && in_ackdel;
	// overload only as reaction to dominant in intermission
	wire logic ovl_e   = !busy && (FIELD == can_err_pkg::FLD_INTER) && rx_dom;
	wire logic passive = (TX_ERR_CNT > can_err_pkg::PASS_LIM)
		|| ({1'b0, RX_ERR_CNT} > can_err_pkg::PASS_LIM);
	wire logic boff    = TX_ERR_CNT > can_err_pkg::BOFF_LIM;
	wire logic warn    = (TX_ERR_CNT > can_err_pkg::WARN_LIM)
		|| ({1'b0, RX_ERR_CNT} > can_err_pkg::WARN_LIM);
	wire logic start_f = now_e || late_e || dev_e || ovl_e;
	wire logic drive_d = (state_d == can_err_pkg::SIG_FLAG);
	wire logic tx_stuff = !busy && TX_ACTIVE && STUFF_FIELD && stuff_next_q;

	// ------------------------------------------------------------
	// signalling state machine
	// ------------------------------------------------------------
	always_comb
	begin
		state_d      = state_q;
		cnt_d        = cnt_q;
		ovl_d        = ovl_q;
		crc_pend_d   = crc_pend_q && !FRAME_START;
		run_d        = run_q;
		last_d       = last_q;
		stuff_next_d = stuff_next_q;
		crc_idx_d    = crc_idx_q;
		if (BIT_TICK)
		begin
			// run length for stuffing and destuffing
			if (FRAME_START || !STUFF_FIELD || stuff_next_q)
			begin
				run_d = 3'h1;
				stuff_next_d = 1'b0;
			end
			else
			begin
				run_d = (RX_BIT == last_q) ? run_q + 3'h1 : 3'h1;
				stuff_next_d = (run_d == can_err_pkg::STUFF_RUN);
			end
			last_d = RX_BIT;
			if (FRAME_START || !in_crc)
				crc_idx_d = 4'h0;
			// hold at the last position so the select stays in range
			else if (!stuff_next_q && !crc_last)
				crc_idx_d = crc_idx_q + 4'h1;
			if (crc_e)
				crc_pend_d = 1'b1;
			unique case (state_q)
				can_err_pkg::SIG_IDLE:
				begin
					if (start_f)
					begin
						ovl_d = ovl_e;
						crc_pend_d = 1'b0;
						cnt_d = 3'h0;
						state_d = passive ? can_err_pkg::SIG_PFLAG
							: can_err_pkg::SIG_FLAG;
					end
				end
				can_err_pkg::SIG_FLAG:
				begin
					if (dev_e)
					begin
						ovl_d = 1'b0;
						cnt_d = 3'h0;  // restart as error frame
					end
					else if (cnt_q == can_err_pkg::FLAG_BITS - 3'h1)
						state_d = can_err_pkg::SIG_WAITR;
					else
						cnt_d = cnt_q + 3'h1;
				end
				can_err_pkg::SIG_PFLAG:
				begin
					// six consecutive equal bits, a change restarts the count
					if (cnt_q != 3'h0 && RX_BIT != last_q)
						cnt_d = 3'h1;
					else if (cnt_q == can_err_pkg::FLAG_BITS - 3'h1)
						state_d = can_err_pkg::SIG_WAITR;
					else
						cnt_d = cnt_q + 3'h1;
				end
				can_err_pkg::SIG_WAITR:
				begin
					if (!rx_dom)
					begin
						cnt_d = 3'h0;
						state_d = can_err_pkg::SIG_DELIM;
					end
				end
				can_err_pkg::SIG_DELIM:
				begin
					if (dev_e)
					begin
						ovl_d = 1'b0;
						cnt_d = 3'h0;
						state_d = passive ? can_err_pkg::SIG_PFLAG
							: can_err_pkg::SIG_FLAG;
					end
					else if (cnt_q == can_err_pkg::DELIM_REST - 3'h1)
						state_d = can_err_pkg::SIG_IDLE;
					else
						cnt_d = cnt_q + 3'h1;
				end
				can_err_pkg::SIG_BUSOFF:
				begin
					if (!RESET_REQ && TX_ERR_CNT == 9'h000
						&& RX_ERR_CNT == 8'h00)
						state_d = can_err_pkg::SIG_IDLE;
				end
				default:
					state_d = can_err_pkg::SIG_IDLE;
			endcase
		end
		if (boff)
			state_d = can_err_pkg::SIG_BUSOFF;
	end

	// state registers
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			state_q      <= can_err_pkg::SIG_IDLE;
			cnt_q        <= 3'h0;
			ovl_q        <= 1'b0;
			crc_pend_q   <= 1'b0;
			run_q        <= 3'h0;
			last_q       <= 1'b1;
			stuff_next_q <= 1'b0;
			crc_idx_q    <= 4'h0;
		end
		else
		begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			ovl_q        <= ovl_d;
			crc_pend_q   <= crc_pend_d;
			run_q        <= run_d;
			last_q       <= last_d;
			stuff_next_q <= stuff_next_d;
			crc_idx_q    <= crc_idx_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	wire logic off_d  = (state_d == can_err_pkg::SIG_BUSOFF);
	wire logic busy_d = (state_d != can_err_pkg::SIG_IDLE) && !off_d;
	wire logic ack_dr = !busy && !TX_ACTIVE && in_ack && MSG_VALID;
	wire logic pin_d  = off_d ? can_err_pkg::RECESSIVE
		: (drive_d || ack_dr) ? can_err_pkg::DOMINANT
		: (busy || !TX_ACTIVE) ? can_err_pkg::RECESSIVE
		: TX_BIT;

	// status and pin registers
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			TX_PIN       <= 1'b1;
			STUFF_INSERT <= 1'b0;
			BIT_ERR      <= 1'b0;
			STUFF_ERR    <= 1'b0;
			CRC_ERR      <= 1'b0;
			FORM_ERR     <= 1'b0;
			ACK_ERR      <= 1'b0;
			ARB_LOST     <= 1'b0;
			OVERLOAD     <= 1'b0;
			RETX_REQ     <= 1'b0;
			ERR_PASSIVE  <= 1'b0;
			BUS_OFF      <= 1'b0;
			ERR_WARN     <= 1'b0;
			CRC_OUT_BIT  <= 1'b0;
		end
		else
		begin
			TX_PIN       <= pin_d;
			STUFF_INSERT <= tx_stuff;
			BIT_ERR      <= BIT_TICK && bit_e;
			STUFF_ERR    <= BIT_TICK && stuff_e;
			CRC_ERR      <= BIT_TICK && crc_e;
			FORM_ERR     <= BIT_TICK && (form_e || dev_e);
			ACK_ERR      <= BIT_TICK && ack_e;
			ARB_LOST     <= BIT_TICK && arb_l;
			OVERLOAD     <= ovl_d && busy_d;
			// overload frames never ask for a resend
			RETX_REQ     <= BIT_TICK && TX_ACTIVE && (now_e || late_e);
			ERR_PASSIVE  <= passive;
			BUS_OFF      <= off_d;
			ERR_WARN     <= warn;
			CRC_OUT_BIT  <= crc_bit;
		end
	end
endmodule
`default_nettype wire

// ==== can_peer_node.sv ====
`timescale 1ns/1ps
`default_nettype none
module can_peer_node (
	// bus side
	input  wire logic dut_pin,
	input  wire logic drive_dom,
	// wired-and level seen by all nodes
	output logic      bus
);
	// released line rests recessive, peer pulls dominant on command
	assign bus = dut_pin & ~drive_dom;
endmodule
`default_nettype wire

// ==== can_error_detect_signal_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module can_error_detect_signal_asserts (
	// clock and reset
	input wire logic                CLK,
	input wire logic                SYS_RST,
	// sampled inputs
	input wire logic                BIT_TICK,
	input wire logic                RX_BIT,
	input wire can_err_pkg::field_t FIELD,
	input wire logic                TX_ACTIVE,
	input wire logic                TX_BIT,
	input wire logic                MSG_VALID,
	input wire logic [8:0]          TX_ERR_CNT,
	input wire logic [7:0]          RX_ERR_CNT,
	input wire logic                RESET_REQ,
	// watched outputs
	input wire logic                TX_PIN,
	input wire logic                BIT_ERR,
	input wire logic                FORM_ERR,
	input wire logic                ACK_ERR,
	input wire logic                ARB_LOST,
	input wire logic                OVERLOAD,
	input wire logic                ERR_PASSIVE,
	input wire logic                BUS_OFF,
	input wire logic                ERR_WARN
);
	// ----------
	// bit context
	// ----------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// tick outside bus-off with own drive released
	wire logic t = BIT_TICK && !BUS_OFF && TX_PIN;
	wire logic rxd = t && !RX_BIT;
	wire logic txa = t && TX_ACTIVE && FIELD == can_err_pkg::FLD_ACK;
	wire logic c_ok = BIT_TICK && !BUS_OFF && TX_ERR_CNT <= 9'h0FF;
	wire logic arb = rxd && TX_ACTIVE && TX_BIT
		&& FIELD == can_err_pkg::FLD_ARB;
	wire logic eof = rxd && !TX_ACTIVE && FIELD == can_err_pkg::FLD_EOF;
	wire logic ovl = rxd && !TX_ACTIVE && !OVERLOAD
		&& FIELD == can_err_pkg::FLD_INTER;
	wire logic ack = t && RX_BIT && !TX_ACTIVE && MSG_VALID
		&& FIELD == can_err_pkg::FLD_ACK;
	wire logic hold = BUS_OFF && (RESET_REQ || |TX_ERR_CNT || |RX_ERR_CNT);
	// ----------
	// checks
	// ----------
	AST_ACTIVE_FLAG: assert property (
		BIT_ERR && !ERR_PASSIVE && !$past(ERR_PASSIVE) |-> !TX_PIN)
		else $error("no dominant flag after bit error");
	AST_PASSIVE_FLAG: assert property (
		BIT_ERR && ERR_PASSIVE && $past(ERR_PASSIVE) |-> TX_PIN)
		else $error("passive node drove dominant flag");
	AST_ACK_SLOT: assert property (txa |=> !BIT_ERR)
		else $error("bit error in ack slot");
	AST_ACK_MISS: assert property (txa && RX_BIT |=> ACK_ERR)
		else $error("missing ack not flagged");
	AST_ARB: assert property (arb |=> ARB_LOST && !BIT_ERR)
		else $error("arbitration loss misread");
	AST_FORM: assert property (eof |=> FORM_ERR)
		else $error("dominant end-of-frame not flagged");
	AST_OVL: assert property (ovl |=> OVERLOAD && !TX_PIN)
		else $error("overload not one bit after dominant");
	AST_OVL_CAUSE: assert property (
		$rose(OVERLOAD) |-> $past(BIT_TICK) && !$past(RX_BIT))
		else $error("overload without dominant bit");
	AST_ACK_DRV: assert property (ack |=> !TX_PIN)
		else $error("valid reception not acked");
	AST_WARN: assert property (
		c_ok && (TX_ERR_CNT > 9'h060 || RX_ERR_CNT > 8'h60) |=> ERR_WARN)
		else $error("warning missing");
	AST_PASSIVE: assert property (
		c_ok && (TX_ERR_CNT > 9'h07F || RX_ERR_CNT > 8'h7F) |=> ERR_PASSIVE)
		else $error("error-passive missing");
	AST_BOFF_IN: assert property (
		BIT_TICK && TX_ERR_CNT > 9'h0FF |=> BUS_OFF)
		else $error("bus-off not entered");
	AST_BOFF_HOLD: assert property (hold |=> BUS_OFF)
		else $error("bus-off left too early");
	// main scenarios reached
	cover property (BIT_ERR && !TX_PIN);
	cover property ($rose(OVERLOAD));
	cover property ($rose(BUS_OFF));
endmodule
`default_nettype wire

// ==== can_error_detect_signal_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module can_error_detect_signal_tb;
	// ----------
	// stimulus and observation
	// ----------
	logic clk = 1'h0, rst = 1'h1, tick = 1'h0, act = 1'h0, txb = 1'h1;
	logic stf = 1'h0, fst = 1'h0, mval = 1'h0, rreq = 1'h0, dom = 1'h0;
	logic [8:0] tec = 9'h000;
	logic [7:0] rec = 8'h00;
	can_err_pkg::field_t fld = can_err_pkg::FLD_IDLE;
	wire logic rx, pin, e_bit, e_stf, e_form, e_ack, e_arb, ovl, retx;
	wire logic pas, boff, warn, e_crc, crcb, sins;
	wire logic [5:0] errs = {e_bit, e_stf, e_form, e_ack, e_arb, ovl};
	int n_errors = 0, n_compared = 0, cyc = 0, k, p;
	logic exp_b, bad;
	logic [7:0] lv [4] = '{8'h60, 8'h61, 8'h7F, 8'h80};
	// remainder of a lone one bit: generator without its top term
	localparam logic [14:0] CRC_ONE = 15'h4599;
	// field, {act, txb, dom}, {bit, stuff, form, ack, arb, overload}
	logic [12:0] rows [9] = '{
		{4'h3, 3'h7, 6'h20}, {4'h2, 3'h7, 6'h02},
		{4'h7, 3'h7, 6'h00}, {4'h7, 3'h6, 6'h04},
		{4'h6, 3'h1, 6'h08}, {4'h8, 3'h1, 6'h08},
		{4'h9, 3'h1, 6'h08}, {4'hA, 3'h1, 6'h01},
		{4'hA, 3'h0, 6'h00}};
	can_error_detect_signal u_dut (
		.CLK(clk), .SYS_RST(rst), .BIT_TICK(tick), .RX_BIT(rx), .FIELD(fld),
		.TX_ACTIVE(act), .TX_BIT(txb), .STUFF_FIELD(stf), .FRAME_START(fst),
		.MSG_VALID(mval), .TX_ERR_CNT(tec), .RX_ERR_CNT(rec),
		.RESET_REQ(rreq), .TX_PIN(pin), .STUFF_INSERT(sins),
		.BIT_ERR(e_bit), .STUFF_ERR(e_stf), .CRC_ERR(e_crc),
		.FORM_ERR(e_form), .ACK_ERR(e_ack),
		.ARB_LOST(e_arb), .OVERLOAD(ovl), .RETX_REQ(retx), .ERR_PASSIVE(pas),
		.BUS_OFF(boff), .ERR_WARN(warn), .CRC_OUT_BIT(crcb));
	can_peer_node u_peer (.dut_pin(pin), .drive_dom(dom), .bus(rx));
	// ----------
	// helpers
	// ----------
	always #2 clk = ~clk;
	// cycle ceiling against hangs
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_errors++;
			conclude();
		end
	end
	task automatic conclude;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk1(input logic got, input logic exp, input string s);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %b", $time, s, got);
		end
	endtask
	task automatic chkv(input logic [5:0] got, exp, input string s);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask
	task automatic do_reset;
		rst = 1'h1;
		{dom, mval, rreq, stf, fst, act, tec, rec} = '0;
		txb = 1'h1;
		repeat (4) @(negedge clk);
		rst = 1'h0;
	endtask
	// one sampled bit, outputs read one cycle later
	task automatic bit_tick(input logic [3:0] f, input logic a, b, d);
		@(negedge clk);
		fld = can_err_pkg::field_t'(f);
		act = a;
		txb = b;
		dom = d;
		tick = 1'h1;
		@(negedge clk);
		tick = 1'h0;
	endtask
	task automatic quiet;
		bit_tick(4'h0, 1'h0, 1'h1, 1'h0);
	endtask
	// ----------
	// tests
	// ----------
	initial
	begin
		foreach (rows[i])
		begin
			do_reset();
			bit_tick(rows[i][12:9], rows[i][8], rows[i][7], rows[i][6]);
			chkv(errs, rows[i][5:0], "row");
		end
		$display("rows done");
		do_reset();
		bit_tick(4'h3, 1'h1, 1'h1, 1'h1);
		chk1(retx, 1'h1, "retx");
		for (k = 0; k < 14; k++)
		begin
			if (k < 7)
				chk1(pin, k == 6, "flag bit");
			quiet();
		end
		bit_tick(4'h3, 1'h1, 1'h1, 1'h1);
		chkv(errs, 6'h20, "after delimiter");
		$display("flag done");
		do_reset();
		for (k = 0; k < 4; k++)
		begin
			rec = lv[k];
			quiet();
			chk1(warn, k > 0, "warn");
			chk1(pas, k > 2, "passive");
		end
		bit_tick(4'h3, 1'h1, 1'h1, 1'h1);
		chk1(pin, 1'h1, "passive flag");
		$display("levels done");
		do_reset();
		tec = 9'h0FF;
		quiet();
		chk1(boff, 1'h0, "boff 255");
		tec = 9'h100;
		quiet();
		chk1(boff, 1'h1, "boff 256");
		tec = 9'h000;
		rreq = 1'h1;
		bit_tick(4'h3, 1'h1, 1'h1, 1'h1);
		chkv({e_bit, pin, boff, 3'h0}, 6'h18, "boff hold");
		rreq = 1'h0;
		quiet();
		chk1(boff, 1'h0, "boff exit");
		$display("busoff done");
		do_reset();
		fst = 1'h1;
		quiet();
		fst = 1'h0;
		stf = 1'h1;
		for (k = 0; k < 6; k++)
		begin
			bit_tick(4'h2, 1'h0, 1'h1, 1'h1);
			chk1(e_stf, k == 5, "stuff");
		end
		// transmitter sends five dominant bits, stuff bit follows
		do_reset();
		{stf, act, txb} = 3'h6;
		repeat (5) bit_tick(4'h2, 1'h1, 1'h0, 1'h0);
		@(negedge clk);
		chk1(sins, 1'h1, "stuff insert");
		$display("stuff done");
		do_reset();
		mval = 1'h1;
		bit_tick(4'h7, 1'h0, 1'h1, 1'h0);
		chk1(pin, 1'h0, "ack drive");
		do_reset();
		bit_tick(4'hA, 1'h0, 1'h1, 1'h1);
		chkv({ovl, pin, retx, 3'h0}, 6'h20, "overload");
		// dominant bit inside the overload delimiter
		repeat (7) quiet();
		bit_tick(4'h0, 1'h0, 1'h1, 1'h1);
		chkv({ovl, pin, e_form, 3'h0}, 6'h08, "ovl dev");
		$display("ack and overload done");
		// good sequence, then one corrupted crc bit
		for (p = 0; p < 2; p++)
		begin
			do_reset();
			fst = 1'h1;
			quiet();
			fst = 1'h0;
			bit_tick(4'h1, 1'h0, 1'h1, 1'h0);
			for (k = 0; k < 15; k++)
			begin
				exp_b = CRC_ONE[14 - k];
				bad = (p == 1 && k == 3);
				bit_tick(4'h5, 1'h0, 1'h1, exp_b ~^ bad);
				chk1(e_crc, bad, "crc check");
				chk1(crcb, exp_b, "crc bit");
			end
			bit_tick(4'h6, 1'h0, 1'h1, 1'h0);
			bit_tick(4'h7, 1'h0, 1'h1, 1'h0);
			chk1(pin, 1'h1, "crc flag held");
			bit_tick(4'h8, 1'h0, 1'h1, 1'h0);
			chk1(pin, p == 0, "crc flag late");
		end
		$display("crc done");
		conclude();
	end
endmodule
bind can_error_detect_signal can_error_detect_signal_asserts u_chk (
	.CLK(CLK), .SYS_RST(SYS_RST), .BIT_TICK(BIT_TICK), .RX_BIT(RX_BIT),
	.FIELD(FIELD), .TX_ACTIVE(TX_ACTIVE), .TX_BIT(TX_BIT),
	.MSG_VALID(MSG_VALID), .TX_ERR_CNT(TX_ERR_CNT), .RX_ERR_CNT(RX_ERR_CNT),
	.RESET_REQ(RESET_REQ), .TX_PIN(TX_PIN), .BIT_ERR(BIT_ERR),
	.FORM_ERR(FORM_ERR), .ACK_ERR(ACK_ERR), .ARB_LOST(ARB_LOST),
	.OVERLOAD(OVERLOAD), .ERR_PASSIVE(ERR_PASSIVE), .BUS_OFF(BUS_OFF),
	.ERR_WARN(ERR_WARN));
`default_nettype wire
